// >>> verilog/fcs_top.v
// Purpose: flash command sequencer with apb registers and page latch
// Assumes: flash array acks each page erase, erase-all and page program
// Notes:   latch window aliased over the upper half of the address space
//
// Added by the designer: the placing of the registers and the APB slave port.
`include "fcs_defs.vh"

module fcs_top (
  // clock and reset
  input  wire                        mclk_i,
  input  wire                        arst_n_i,
  // apb slave
  input  wire                        psel_i,
  input  wire                        penable_i,
  input  wire                        pwrite_i,
  input  wire [`FCS_ADDR_W-1:0]      paddr_i,
  input  wire [31:0]                 pwdata_i,
  output reg  [31:0]                 prdata_o,
  output reg                         pready_o,
  output reg                         pslverr_o,
  // flash array
  output reg                         fl_erase_o,
  output reg                         fl_erase_all_o,
  output reg  [`FCS_PAGE_W-1:0]      fl_page_o,
  output reg                         fl_prog_o,
  output reg  [`FCS_WIDX_W-1:0]      fl_widx_o,
  output reg  [31:0]                 fl_wdata_o,
  output reg                         fl_commit_o,
  input  wire                        fl_ack_i,
  // interrupt
  output reg                         irq_o
);

  localparam [2:0] S_IDLE   = 3'd0;
  localparam [2:0] S_ERASE  = 3'd1;
  localparam [2:0] S_PROG   = 3'd2;
  localparam [2:0] S_PWAIT  = 3'd3;
  localparam [2:0] S_FINISH = 3'd4;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [31:0]              latch_q [0:`FCS_PAGE_WORDS-1];
  reg                     ien_q;
  reg [3:0]               ws_cfg_q;
  reg                     done_q;
  reg                     cerr_q;
  reg                     lerr_q;
  reg [`FCS_NLOCK-1:0]    lock_q;
  reg [2:0]               state_q;
  reg [3:0]               cmd_q;
  reg [`FCS_PAGE_W-1:0]   page_q;
  reg [`FCS_WIDX_W-1:0]   widx_q;
  reg                     desc_on_q;
  reg [`FCS_DIDX_W-1:0]   didx_q;
  reg [3:0]               ws_cnt_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire                    setup    = psel_i & ~penable_i;
  wire                    acc_done = psel_i & penable_i & pready_o;
  wire                    is_latch = paddr_i[`FCS_LATCH_SEL_BIT];
  wire [`FCS_WIDX_W-1:0]  lidx     = paddr_i[`FCS_LATCH_IDX_HI:`FCS_LATCH_IDX_LO];
  wire [3:0]              code     = pwdata_i[`FCS_CODE_HI:`FCS_CODE_LO];
  wire [`FCS_PAGE_W-1:0]  arg_page = pwdata_i[`FCS_PAGE_W-1+`FCS_ARG_LO:`FCS_ARG_LO];
  wire [3:0]              arg_reg  = arg_page[`FCS_PAGE_W-1:`FCS_REGION_SHIFT];
  wire                    key_ok   = (pwdata_i[`FCS_KEY_HI:`FCS_KEY_LO] == `FCS_KEY);
  wire                    wr_cmd   = acc_done & pwrite_i & ~is_latch & (paddr_i == `FCS_OFF_CMD);
  wire                    rd_stat  = acc_done & ~pwrite_i & ~is_latch & (paddr_i == `FCS_OFF_STATUS);
  wire                    rd_res   = acc_done & ~pwrite_i & ~is_latch & (paddr_i == `FCS_OFF_RESULT);
  wire                    busy     = (state_q != S_IDLE);
  reg                     code_ok;
  reg                     is_prog;
  reg                     is_erase;

  always @* begin
    code_ok  = 1'b0;
    is_prog  = 1'b0;
    is_erase = 1'b0;
    case (code)
      `FCS_CMD_GET_DESCRIPTOR_CMD, `FCS_CMD_SETLK, `FCS_CMD_CLRLK: code_ok = 1'b1;
      `FCS_CMD_WP, `FCS_CMD_WPL: begin
        code_ok = 1'b1;
        is_prog = 1'b1;
      end
      `FCS_CMD_EWP, `FCS_CMD_ERASE_WRITE_LOCK_CMD: begin
        code_ok  = 1'b1;
        is_prog  = 1'b1;
        is_erase = 1'b1;
      end
      `FCS_CMD_EA: begin
        code_ok  = 1'b1;
        is_erase = 1'b1;
      end
      default: code_ok = 1'b0;
    endcase
  end

  wire cmd_take = wr_cmd & key_ok & code_ok & ~busy;
  wire lock_hit = (code == `FCS_CMD_EA) ? (|lock_q) : ((is_prog | is_erase) & lock_q[arg_reg]);
  wire cmd_run  = cmd_take & ~lock_hit;

  // ----------------------------------------
  // descriptor words
  // ----------------------------------------
  function [31:0] desc_word;
    input [`FCS_DIDX_W-1:0] i;
    begin
      if (i == `FCS_DIDX_W'd0)
        desc_word = `FCS_DESC_ID;
      else if (i == `FCS_DIDX_W'd1)
        desc_word = `FCS_DESC_SIZE;
      else if (i == `FCS_DIDX_W'd2)
        desc_word = `FCS_DESC_PAGE;
      else if (i == `FCS_DIDX_W'd3)
        desc_word = `FCS_DESC_PLANES;
      else if (i == `FCS_DIDX_PLANE0)
        desc_word = `FCS_DESC_SIZE;
      else if (i == `FCS_DIDX_NLOCK)
        desc_word = `FCS_DESC_NLOCK;
      else if (i < `FCS_DIDX_END)
        desc_word = `FCS_DESC_REGION;
      else
        desc_word = 32'h0000_0000;
    end
  endfunction

  wire [31:0] result_val = desc_on_q ? desc_word(didx_q) : 32'h0000_0000;

  // ----------------------------------------
  // apb answer path
  // ----------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      ws_cnt_q  <= 4'h0;
    end else if (acc_done) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (is_latch) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : latch_q[lidx];
        ws_cnt_q <= ws_cfg_q;
        pready_o <= (ws_cfg_q == 4'h0);
      end else begin
        pready_o <= 1'b1;
        if (paddr_i == `FCS_OFF_MODE)
          prdata_o <= {20'h0_0000, ws_cfg_q, 7'h00, ien_q};
        else if (paddr_i == `FCS_OFF_STATUS)
          prdata_o <= {29'h000_0000, lerr_q, cerr_q, done_q};
        else if (paddr_i == `FCS_OFF_RESULT)
          prdata_o <= result_val;
        else if (paddr_i != `FCS_OFF_CMD)
          pslverr_o <= 1'b1;
      end
    end else if (psel_i & penable_i & ~pready_o) begin
      ws_cnt_q <= ws_cnt_q - 4'h1;
      if (ws_cnt_q == 4'h1)
        pready_o <= 1'b1;
    end
  end

  // ----------------------------------------
  // page latch, aliased over its window
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (acc_done & pwrite_i & is_latch)
      latch_q[lidx] <= pwdata_i;
  end

  // ----------------------------------------
  // mode and status
  // ----------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ien_q    <= 1'b0;
      ws_cfg_q <= 4'h0;
      cerr_q   <= 1'b0;
      lerr_q   <= 1'b0;
      irq_o    <= 1'b0;
    end else begin
      if (acc_done & pwrite_i & ~is_latch & (paddr_i == `FCS_OFF_MODE)) begin
        ien_q    <= pwdata_i[`FCS_MODE_IEN_BIT];
        ws_cfg_q <= pwdata_i[`FCS_MODE_WS_HI:`FCS_MODE_WS_LO];
      end
      // set wins over the read clear
      if (wr_cmd & ~cmd_take)
        cerr_q <= 1'b1;
      else if (rd_stat)
        cerr_q <= 1'b0;
      if (cmd_take & lock_hit)
        lerr_q <= 1'b1;
      else if (rd_stat)
        lerr_q <= 1'b0;
      irq_o <= done_q & ien_q;
    end
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q        <= S_IDLE;
      cmd_q          <= 4'h0;
      page_q         <= {`FCS_PAGE_W{1'b0}};
      widx_q         <= {`FCS_WIDX_W{1'b0}};
      done_q         <= 1'b1;
      lock_q         <= {`FCS_NLOCK{1'b0}};
      desc_on_q      <= 1'b0;
      didx_q         <= {`FCS_DIDX_W{1'b0}};
      fl_erase_o     <= 1'b0;
      fl_erase_all_o <= 1'b0;
      fl_page_o      <= {`FCS_PAGE_W{1'b0}};
      fl_prog_o      <= 1'b0;
      fl_widx_o      <= {`FCS_WIDX_W{1'b0}};
      fl_wdata_o     <= 32'h0000_0000;
      fl_commit_o    <= 1'b0;
    end else begin
      fl_erase_o     <= 1'b0;
      fl_erase_all_o <= 1'b0;
      fl_prog_o      <= 1'b0;
      fl_commit_o    <= 1'b0;
      if (rd_res & desc_on_q & (didx_q != `FCS_DIDX_END))
        didx_q <= didx_q + `FCS_DIDX_W'd1;
      case (state_q)
        S_IDLE: begin
          if (cmd_run) begin
            done_q    <= 1'b0;
            desc_on_q <= 1'b0;
            cmd_q     <= code;
            page_q    <= arg_page;
            fl_page_o <= arg_page;
            widx_q    <= {`FCS_WIDX_W{1'b0}};
            if (is_erase) begin
              fl_erase_o     <= (code != `FCS_CMD_EA);
              fl_erase_all_o <= (code == `FCS_CMD_EA);
              state_q        <= S_ERASE;
            end else if (is_prog) begin
              state_q <= S_PROG;
            end else begin
              state_q <= S_FINISH;
            end
          end
        end
        S_ERASE: begin
          if (fl_ack_i)
            state_q <= (cmd_q == `FCS_CMD_EA) ? S_FINISH : S_PROG;
        end
        S_PROG: begin
          fl_prog_o  <= 1'b1;
          fl_widx_o  <= widx_q;
          fl_wdata_o <= latch_q[widx_q];
          widx_q     <= widx_q + `FCS_WIDX_W'd1;
          if (widx_q == `FCS_WIDX_LAST) begin
            fl_commit_o <= 1'b1;
            state_q     <= S_PWAIT;
          end
        end
        S_PWAIT: begin
          if (fl_ack_i)
            state_q <= S_FINISH;
        end
        default: begin
          if ((cmd_q == `FCS_CMD_WPL) | (cmd_q == `FCS_CMD_ERASE_WRITE_LOCK_CMD) | (cmd_q == `FCS_CMD_SETLK))
            lock_q[page_q[`FCS_PAGE_W-1:`FCS_REGION_SHIFT]] <= 1'b1;
          if (cmd_q == `FCS_CMD_CLRLK)
            lock_q[page_q[`FCS_PAGE_W-1:`FCS_REGION_SHIFT]] <= 1'b0;
          if (cmd_q == `FCS_CMD_GET_DESCRIPTOR_CMD) begin
            desc_on_q <= 1'b1;
            didx_q    <= {`FCS_DIDX_W{1'b0}};
          end
          done_q  <= 1'b1;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule // fcs_top

// >>> verilog/fcs_defs.vh
// Purpose: constants of the flash command sequencer
// Assumes: apb byte addresses, 32-bit data
// Notes:   definitions only
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define FCS_ADDR_W        16
`define FCS_OFF_MODE      16'h0000
`define FCS_OFF_CMD       16'h0004
`define FCS_OFF_STATUS    16'h0008
`define FCS_OFF_RESULT    16'h000c
`define FCS_LATCH_SEL_BIT 15
`define FCS_LATCH_IDX_HI  7
`define FCS_LATCH_IDX_LO  2

// ----------------------------------------
// fields
// ----------------------------------------
`define FCS_MODE_IEN_BIT  0
`define FCS_MODE_WS_HI    11
`define FCS_MODE_WS_LO    8
`define FCS_ST_DONE_BIT   0
`define FCS_ST_CERR_BIT   1
`define FCS_ST_LERR_BIT   2
`define FCS_KEY_HI        31
`define FCS_KEY_LO        24
`define FCS_ARG_HI        16
`define FCS_ARG_LO        8
`define FCS_CODE_HI       3
`define FCS_CODE_LO       0
`define FCS_KEY           8'hc3

// ----------------------------------------
// command codes
// ----------------------------------------
`define FCS_CMD_GET_DESCRIPTOR_CMD      4'h0
`define FCS_CMD_WP        4'h1
`define FCS_CMD_WPL       4'h2
`define FCS_CMD_EWP       4'h3
`define FCS_CMD_ERASE_WRITE_LOCK_CMD      4'h4
`define FCS_CMD_EA        4'h5
`define FCS_CMD_SETLK     4'h8
`define FCS_CMD_CLRLK     4'h9

// ----------------------------------------
// geometry and descriptor
// ----------------------------------------
`define FCS_PAGE_WORDS    64
`define FCS_WIDX_W        6
`define FCS_WIDX_LAST     6'h3f
`define FCS_PAGE_W        9
`define FCS_NLOCK         16
`define FCS_REGION_SHIFT  5
`define FCS_DIDX_W        5
`define FCS_DESC_ID       32'h0000_0a5e
`define FCS_DESC_SIZE     32'h0002_0000
`define FCS_DESC_PAGE     32'h0000_0100
`define FCS_DESC_PLANES   32'h0000_0001
`define FCS_DESC_NLOCK    32'h0000_0010
`define FCS_DESC_REGION   32'h0000_2000
`define FCS_DIDX_PLANE0   5'h04
`define FCS_DIDX_NLOCK    5'h05
`define FCS_DIDX_END      5'h16

`endif

// >>> testbench/fcs_flash_model.sv
// Purpose: flash array stand-in, acks erase and program
// Assumes: one operation at a time
// Notes:   busy for DLY cycles per operation
module fcs_flash_model #(
  parameter int DLY = 12
) (
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  input  wire logic        erase_i,
  input  wire logic        erase_all_i,
  input  wire logic [8:0]  page_i,
  input  wire logic        prog_i,
  input  wire logic [5:0]  widx_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        commit_i,
  output logic             ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] page_q [64];
  logic [8:0]  erase_page;
  int          n_erase, n_erase_all, n_commit, cnt;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 0;
      ack_o <= 1'b0;
      n_erase <= 0;
      n_erase_all <= 0;
      n_commit <= 0;
    end else begin
      ack_o <= (cnt == 1);
      if (cnt != 0)
        cnt <= cnt - 1;
      if (erase_i || erase_all_i || commit_i)
        cnt <= DLY;
      if (prog_i)
        page_q[widx_i] <= wdata_i;
      if (erase_i) begin
        n_erase <= n_erase + 1;
        erase_page <= page_i;
      end
      if (erase_all_i)
        n_erase_all <= n_erase_all + 1;
      if (commit_i)
        n_commit <= n_commit + 1;
    end
  end
endmodule // fcs_flash_model

// >>> testbench/fcs_top_properties.sv
// Purpose: port-level checks of the command sequencer
// Assumes: single clock, async active-low reset
// Notes:   mode register shadowed from apb writes
`include "fcs_defs.vh"
module fcs_top_properties (
  input wire                   mclk_i,
  input wire                   arst_n_i,
  input wire                   psel_i,
  input wire                   penable_i,
  input wire                   pwrite_i,
  input wire [`FCS_ADDR_W-1:0] paddr_i,
  input wire [31:0]            pwdata_i,
  input wire                   pready_o,
  input wire                   fl_erase_o,
  input wire                   fl_erase_all_o,
  input wire                   fl_prog_o,
  input wire [5:0]             fl_widx_o,
  input wire                   fl_commit_o,
  input wire                   fl_ack_i,
  input wire                   irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  reg [3:0] ws_q;
  reg [3:0] acc_q;
  reg       ien_q;
  wire      done_w = psel_i & penable_i & pready_o;
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ws_q <= 4'h0;
      ien_q <= 1'b0;
      acc_q <= 4'h0;
    end else begin
      if (done_w && pwrite_i && paddr_i == `FCS_OFF_MODE) begin
        ws_q <= pwdata_i[11:8];
        ien_q <= pwdata_i[0];
      end
      acc_q <= (psel_i & penable_i & !pready_o) ? acc_q + 4'h1 : 4'h0;
    end
  end
  sequence s_latch_acc;
    done_w && paddr_i[15];
  endsequence
  sequence s_bad_cmd;
    done_w && pwrite_i && paddr_i == `FCS_OFF_CMD && pwdata_i[31:24] != `FCS_KEY && !fl_prog_o && !fl_ack_i;
  endsequence
  chk_latch_wait: assert property (s_latch_acc |-> acc_q == ws_q) else $error("latch wait wrong");
  chk_reg_nowait: assert property (done_w && !paddr_i[15] |-> acc_q == 4'h0) else $error("reg wait");
  chk_ready_in_access: assert property (pready_o |-> psel_i && penable_i) else $error("stray ready");
  chk_bad_key_quiet: assert property (s_bad_cmd |=> !(fl_erase_o || fl_erase_all_o) ##1 !fl_prog_o)
    else $error("bad key acted");
  chk_prog_first: assert property ($rose(fl_prog_o) |-> fl_widx_o == 6'h00) else $error("first idx");
  chk_widx_step: assert property (fl_prog_o && fl_widx_o != 6'h3f |=> fl_prog_o && fl_widx_o == $past(fl_widx_o) + 6'h1)
    else $error("index step");
  chk_commit_last: assert property (fl_commit_o |-> fl_prog_o && fl_widx_o == 6'h3f) else $error("commit");
  chk_irq_masked: assert property (!$past(ien_q) |-> !irq_o) else $error("irq while masked");
endmodule // fcs_top_properties
bind fcs_top fcs_top_properties u_props (.mclk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pready_o, .fl_erase_o, .fl_erase_all_o, .fl_prog_o, .fl_widx_o, .fl_commit_o, .fl_ack_i, .irq_o);

// >>> testbench/flash_command_sequencer_test.sv
// Purpose: apb-driven test of the command sequencer
// Assumes: flash stand-in acks after a fixed delay
// Notes:   status read result kept in st
`include "fcs_defs.vh"
module flash_command_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0, arst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [15:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd, st, fl_wdata_o;
  logic        pready_o, pslverr_o, fl_erase_o, fl_erase_all_o, fl_prog_o, fl_commit_o, irq_o, fl_ack_i, slverr;
  logic [8:0]  fl_page_o;
  logic [5:0]  fl_widx_o;
  int          n_fail = 0, n_compared = 0, i;
  always #4 mclk_i = ~mclk_i;
  fcs_top DUT (.mclk_i, .arst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .fl_erase_o, .fl_erase_all_o, .fl_page_o, .fl_prog_o, .fl_widx_o, .fl_wdata_o, .fl_commit_o,
    .fl_ack_i, .irq_o);
  fcs_flash_model #(.DLY(12)) u_fl (.mclk_i, .arst_n_i, .erase_i(fl_erase_o), .erase_all_i(fl_erase_all_o),
    .page_i(fl_page_o), .prog_i(fl_prog_o), .widx_i(fl_widx_o), .wdata_i(fl_wdata_o), .commit_i(fl_commit_o),
    .ack_o(fl_ack_i));
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    slverr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wait_done;
    for (int k = 0; k < 300; k++) begin
      xfer(1'b0, `FCS_OFF_STATUS, 32'h0);
      if (rd[0] === 1'b1) break;
    end
    st = rd;
  endtask
  task automatic cmd(input logic [8:0] pg, input logic [3:0] c);
    xfer(1'b1, `FCS_OFF_CMD, {`FCS_KEY, 7'h00, pg, 4'h0, c});
    wait_done;
  endtask
  function automatic logic [31:0] desc(input int k);
    if (k == 0) return `FCS_DESC_ID;
    if (k == 1 || k == 4) return `FCS_DESC_SIZE;
    if (k == 2) return `FCS_DESC_PAGE;
    if (k == 3) return `FCS_DESC_PLANES;
    if (k == 4 + 1) return `FCS_DESC_NLOCK;
    if (k < 4 + 1 + 1 + 16) return `FCS_DESC_REGION;
    return 32'h0;
  endfunction
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk_i);
    n_fail++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    xfer(1'b0, `FCS_OFF_STATUS, 32'h0);
    chk("status reset", rd, 32'h1);
    xfer(1'b0, 16'h0010, 32'h0);
    chk("unmapped", {31'h0, slverr}, 32'h1);
    cmd(9'h0, `FCS_CMD_GET_DESCRIPTOR_CMD);
    for (i = 0; i < 24; i++) begin
      xfer(1'b0, `FCS_OFF_RESULT, 32'h0);
      chk("descriptor", rd, desc(i));
    end
    cmd(9'h0, `FCS_CMD_GET_DESCRIPTOR_CMD);
    xfer(1'b0, `FCS_OFF_RESULT, 32'h0);
    chk("desc restart", rd, desc(0));
    xfer(1'b1, `FCS_OFF_CMD, 32'h1200_0001);
    xfer(1'b0, `FCS_OFF_STATUS, 32'h0);
    chk("bad key", rd, 32'h3);
    xfer(1'b0, `FCS_OFF_STATUS, 32'h0);
    chk("error cleared", rd, 32'h1);
    cmd(9'h0, 4'h6);
    chk("bad code", st, 32'h3);
    cmd(9'd0, `FCS_CMD_EA);
    xfer(1'b1, `FCS_OFF_MODE, 32'h0000_0201);
    for (i = 0; i < 64; i++)
      xfer(1'b1, 16'h8300 + 16'(i * 4), 32'ha500_0000 + i);
    xfer(1'b0, 16'h801c, 32'h0);
    chk("latch alias", rd, 32'ha500_0007);
    xfer(1'b1, `FCS_OFF_CMD, {`FCS_KEY, 7'h00, 9'd3, 4'h0, `FCS_CMD_WP});
    xfer(1'b0, `FCS_OFF_STATUS, 32'h0);
    chk("done cleared", rd, 32'h0);
    wait_done;
    chk("write status", st, 32'h1);
    chk("irq", {31'h0, irq_o}, 32'h1);
    chk("no erase", u_fl.n_erase, 0);
    chk("last word", u_fl.page_q[63], 32'ha500_003f);
    cmd(9'd5, `FCS_CMD_ERASE_WRITE_LOCK_CMD);
    chk("erased page", {23'h0, u_fl.erase_page}, 32'd5);
    chk("programmed", u_fl.n_commit, 2);
    cmd(9'd7, `FCS_CMD_WP);
    chk("locked write", st, 32'h5);
    chk("nothing issued", u_fl.n_commit, 2);
    cmd(9'd0, `FCS_CMD_EA);
    chk("locked erase", st, 32'h5);
    chk("no erase all", u_fl.n_erase_all, 1);
    cmd(9'd5, `FCS_CMD_CLRLK);
    cmd(9'd0, `FCS_CMD_EA);
    chk("erase all", u_fl.n_erase_all, 2);
    cmd(9'd9, `FCS_CMD_EWP);
    chk("erase page 9", {23'h0, u_fl.erase_page}, 32'd9);
    cmd(9'd40, `FCS_CMD_WPL);
    chk("write lock", st, 32'h1);
    cmd(9'd41, `FCS_CMD_EWP);
    chk("region locked", st, 32'h5);
    xfer(1'b1, `FCS_OFF_MODE, 32'h0);
    xfer(1'b0, `FCS_OFF_MODE, 32'h0);
    chk("irq masked", {31'h0, irq_o}, 32'h0);
    wrap_up;
  end
endmodule // flash_command_sequencer_test
